// ==== memory_space_decoder_defines.vh ====
// Address map, target codes and field positions for the memory space decoder.
// What this block does
// - 16 MB linear space, 64 KB segments, 16 KB pages.
// - Every location takes byte and word accesses.
// - Top 256 dual-port RAM bytes bit-addressable.
// - Active register bank words bit-addressable.
// - Data RAM, dual-port RAM and the E000, F000 and FE00 register areas in segment 0.
// - Reserved regions go to external bus when present.
// - Two 512-byte register areas at FE00 and F000.
// - Special registers are word wide.
// - Fetches go through the code fetch manager.
// - Data transfers go through the data transfer manager.
// - System bus lets both managers work concurrently.
// - Program RAM E00000-E03FFF, code side, write-protect section.
// - Data RAM A000-DFFF on its own lane.
// - Standby RAM 8 KB on its own lane.
// - Flash 64 KB at C40000, 256 KB at C00000.
// - Flash 4 KB sectors, 128-byte program blocks.
// - Sector 15 C0F000-C0FFFF reserved for internal use.
// - Flash reads 128-bit lines, error corrected.
// - Flash read protection, password unlocks temporarily.
// - Write protection per sector cluster.
`ifndef MEMORY_SPACE_DECODER_DEFINES_VH
`define MEMORY_SPACE_DECODER_DEFINES_VH
// *****************************************
// Target codes
// *****************************************
`define TGT_DRAM 4'h0
`define TGT_DUAL 4'h1
`define TGT_STBY 4'h2
`define TGT_SPEC 4'h3
`define TGT_EXTD 4'h4
`define TGT_XREG 4'h5
`define TGT_FLREG 4'h6
`define TGT_PERIPH 4'h7
`define TGT_EXT 4'h8
`define TGT_FLASH0 4'h9
`define TGT_FLASH1 4'hA
`define TGT_PRAM 4'hB
`define TGT_EPRAM 4'hC
`define TGT_FLRSV 4'hD
`define TGT_FIRST_CODE 4'h9
`define LANE_EXTBUS 3'h7
// *****************************************
// Region boundaries, 24-bit byte addresses
// *****************************************
`define FLREG_LO 24'hFFFF00
`define RSVD_HI_LO 24'hF00000
`define EPRAM_LO 24'hE80000
`define PRAM_LO 24'hE00000
`define PRAM_HI 24'hE03FFF
`define RSVD_FL_LO 24'hC50000
`define FLASH1_LO 24'hC40000
`define FLRSV_LO 24'hC0F000
`define FLRSV_HI 24'hC0FFFF
`define FLASH0_LO 24'hC00000
`define EXTMEM_LO 24'h400000
`define EXTIO_LO 24'h210000
`define STBY_LO 24'h20C000
`define STBY_HI 24'h20DFFF
`define PERIPH_HI 24'h20BBFF
`define PERIPH_LO 24'h200000
`define EXTLOW_LO 24'h010000
`define SPEC_LO 24'h00FE00
`define DUAL_LO 24'h00F600
`define DUAL_BIT_LO 24'h00FD00
`define RSVD_DU_LO 24'h00F200
`define EXTD_LO 24'h00F000
`define XREG_LO 24'h00E000
`define DRAM_LO 24'h00A000
`define RSVD_DR_LO 24'h008000
// *****************************************
// Field positions
// *****************************************
`define PRAM_OFS_MSB 13
`define BANK_BYTES 16'h0020
`endif

// ==== region_decode.v ====
// Combinational mapping of a 24-bit address onto one target code.
`timescale 1ns/10ps
`default_nettype none
`include "memory_space_decoder_defines.vh"
module region_decode (
   input wire [23:0] addr,
   output reg [3:0] tgt
);
   // *****************************************
   // Priority chain
   // *****************************************
   // Tested from the top down, so each address takes exactly one branch.
   always @* begin
      if (addr >= `FLREG_LO) tgt = `TGT_FLREG;
      else if (addr >= `RSVD_HI_LO) tgt = `TGT_EXT;
      else if (addr >= `EPRAM_LO) tgt = `TGT_EPRAM;
      else if (addr >= `PRAM_LO) tgt = `TGT_PRAM;
      else if (addr >= `RSVD_FL_LO) tgt = `TGT_EXT;
      else if (addr >= `FLASH1_LO) tgt = `TGT_FLASH1;
      else if (addr >= `FLRSV_LO && addr <= `FLRSV_HI) tgt = `TGT_FLRSV;
      else if (addr >= `FLASH0_LO) tgt = `TGT_FLASH0;
      else if (addr >= `EXTIO_LO) tgt = `TGT_EXT;
      else if (addr >= `STBY_LO && addr <= `STBY_HI) tgt = `TGT_STBY;
      else if (addr >= `PERIPH_LO && addr <= `PERIPH_HI) tgt = `TGT_PERIPH;
      else if (addr >= `EXTLOW_LO) tgt = `TGT_EXT;
      else if (addr >= `SPEC_LO) tgt = `TGT_SPEC;
      else if (addr >= `DUAL_LO) tgt = `TGT_DUAL;
      else if (addr >= `RSVD_DU_LO) tgt = `TGT_EXT;
      else if (addr >= `EXTD_LO) tgt = `TGT_EXTD;
      else if (addr >= `XREG_LO) tgt = `TGT_XREG;
      else if (addr >= `DRAM_LO) tgt = `TGT_DRAM;
      else tgt = `TGT_EXT;
   end
endmodule
`default_nettype wire

// ==== flash_guard.v ====
// Flash read lock, password unlock and cluster write protection.
`timescale 1ns/10ps
`default_nettype none
`include "memory_space_decoder_defines.vh"
module flash_guard (
   input wire clk,
   input wire rst_n,
   input wire pwStb,
   input wire [15:0] pwData,
   input wire [15:0] pwdWord0,
   input wire [15:0] pwdWord1,
   input wire relock,
   input wire rdProtEn,
   input wire isFlash1,
   input wire [23:0] flAddr,
   input wire [19:0] wpCluster,
   output wire rdBlock,
   output wire wpHit,
   output wire unlocked
);
   reg stage_r;
   reg unlocked_r;
   wire [6:0] sector;
   wire [4:0] cluster;
   // *****************************************
   // Password sequence
   // *****************************************
   // Two matching writes in a row unlock; any other write restarts.
   // A completed unlock in the relock cycle wins, so it is never lost.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_r <= 1'b0;
         unlocked_r <= 1'b0;
      end else begin
         if (pwStb) begin
            stage_r <= !stage_r && (pwData == pwdWord0);
         end
         if (pwStb && stage_r && pwData == pwdWord1) begin
            unlocked_r <= 1'b1;
         end else if (relock) begin
            unlocked_r <= 1'b0;
         end
      end
   end
   // Sectors of module 0 come first, those of module 1 follow at 64.
   assign sector = isFlash1 ? {3'b100, flAddr[15:12]}
                            : {1'b0, flAddr[17:12]};
   assign cluster = sector[6:2];
   assign wpHit = wpCluster[cluster] && !unlocked_r;
   assign rdBlock = rdProtEn && !unlocked_r;
   assign unlocked = unlocked_r;
endmodule
`default_nettype wire

// ==== memory_space_decoder.v ====
// Top of the memory space decoder: two masters, code and data channels.
`timescale 1ns/10ps
`default_nettype none
`include "memory_space_decoder_defines.vh"
module memory_space_decoder (
   input wire clk,
   input wire rst_n,
   input wire hasExtBus,
   input wire [15:0] contextPtr,
   input wire rdProtEn,
   input wire [15:0] pwdWord0,
   input wire [15:0] pwdWord1,
   input wire relock,
   input wire [19:0] wpCluster,
   input wire [13:0] pramWpTop,
   input wire fReq,
   input wire [23:0] fAddr,
   output wire fRdy,
   output reg fValid_r,
   output reg [15:0] fData_r,
   output reg fErr_r,
   input wire dReq,
   input wire dWe,
   input wire dByte,
   input wire [23:0] dAddr,
   input wire [15:0] dWdata,
   output wire dRdy,
   output reg dValid_r,
   output reg [15:0] dRdata_r,
   output reg dErr_r,
   output reg dBitOk_r,
   output wire flashUnlocked,
   output reg [3:0] cSel_r,
   output reg [23:0] cAddr_r,
   output reg cWe_r,
   output reg [1:0] cBe_r,
   output reg [15:0] cWdata_r,
   input wire cAck,
   input wire [127:0] cLine,
   input wire cEccErr,
   output reg [7:0] xSel_r,
   output reg [23:0] xAddr_r,
   output reg xWe_r,
   output reg [1:0] xBe_r,
   output reg [15:0] xWdata_r,
   input wire xAck,
   input wire [15:0] xRdata
);
   // *****************************************
   // Local types
   // *****************************************
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_BUSY = 2'b01;
   localparam [1:0] ST_FAIL = 2'b10;
   localparam [1:0] ST_NULL = 2'b11;

   wire [3:0] fTgt;
   wire [3:0] dTgt;
   wire fCode;
   wire dCode;
   reg fBusy_r;
   reg dBusy_r;
   reg [1:0] cState_r;
   reg [1:0] cState_nxt;
   reg cOwnF_r;
   reg cByte_r;
   reg [1:0] xState_r;
   reg [1:0] xState_nxt;
   reg xOwnF_r;
   reg xByte_r;
   wire cGrantF;
   wire cGrantD;
   wire xGrantD;
   wire xGrantF;
   wire cGrant;
   wire xGrant;
   wire [23:0] cInAddr;
   wire [3:0] cInTgt;
   wire cInWe;
   wire cInByte;
   wire [23:0] xInAddr;
   wire [3:0] xInTgt;
   wire xInWe;
   wire xInByte;
   wire rdBlock;
   wire wpHit;
   wire cRefuse;
   wire xToBus;
   wire [2:0] xLane;
   wire [1:0] cLane;
   wire [15:0] cWord;
   wire [15:0] cResult;
   wire [15:0] xResult;
   wire cDone;
   wire xDone;
   wire bitOk;
   wire [15:0] bankOfs;

   // *****************************************
   // Address decode
   // *****************************************
   // One decoder per master, so both can be routed in the same cycle.
   region_decode fetchDecode (
      .addr(fAddr),
      .tgt(fTgt)
   );

   region_decode dataDecode (
      .addr(dAddr),
      .tgt(dTgt)
   );

   // Code-side targets sit at the top of the code space.
   assign fCode = fTgt >= `TGT_FIRST_CODE;
   assign dCode = dTgt >= `TGT_FIRST_CODE;

   // *****************************************
   // Channel arbitration
   // *****************************************
   // The code channel favours fetches and the data channel favours data,
   // so each master keeps its own path fast and only crossings wait.
   assign cGrantF = fReq && !fBusy_r && fCode && cState_r == ST_IDLE;
   assign cGrantD = dReq && !dBusy_r && dCode && cState_r == ST_IDLE
                    && !cGrantF;
   assign xGrantD = dReq && !dBusy_r && !dCode
                    && xState_r == ST_IDLE;
   assign xGrantF = fReq && !fBusy_r && !fCode && xState_r == ST_IDLE
                    && !xGrantD;
   assign cGrant = cGrantF || cGrantD;
   assign xGrant = xGrantD || xGrantF;
   assign fRdy = cGrantF || xGrantF;
   assign dRdy = cGrantD || xGrantD;

   // Request fields as seen by each channel; fetches are word reads.
   assign cInAddr = cGrantF ? fAddr : dAddr;
   assign cInTgt = cGrantF ? fTgt : dTgt;
   assign cInWe = cGrantD && dWe;
   assign cInByte = cGrantD && dByte;
   assign xInAddr = xGrantF ? fAddr : dAddr;
   assign xInTgt = xGrantF ? fTgt : dTgt;
   assign xInWe = xGrantD && dWe;
   assign xInByte = xGrantD && dByte;

   // *****************************************
   // Flash protection
   // *****************************************
   // Password words arrive as data writes to the flash register page.
   flash_guard guard (
      .clk(clk),
      .rst_n(rst_n),
      .pwStb(xGrantD && dWe && dTgt == `TGT_FLREG),
      .pwData(dWdata),
      .pwdWord0(pwdWord0),
      .pwdWord1(pwdWord1),
      .relock(relock),
      .rdProtEn(rdProtEn),
      .isFlash1(cInTgt == `TGT_FLASH1),
      .flAddr(cInAddr),
      .wpCluster(wpCluster),
      .rdBlock(rdBlock),
      .wpHit(wpHit),
      .unlocked(flashUnlocked)
   );

   // Refused code requests reach no target. Fetches from a locked
   // flash stay legal so the program keeps running.
   assign cRefuse = cInTgt == `TGT_FLRSV
      || (cGrantD && !dWe && rdBlock
          && (cInTgt == `TGT_FLASH0 || cInTgt == `TGT_FLASH1))
      || (cInWe && wpHit
          && (cInTgt == `TGT_FLASH0 || cInTgt == `TGT_FLASH1))
      || (cInWe && cInTgt == `TGT_PRAM
          && cInAddr[`PRAM_OFS_MSB:0] < pramWpTop);

   // *****************************************
   // Lane selection
   // *****************************************
   // On-chip targets always answer; external areas only with a bus.
   assign xToBus = xInTgt != `TGT_EXT || hasExtBus;
   assign xLane = xInTgt == `TGT_EXT ? `LANE_EXTBUS : xInTgt[2:0];
   assign cLane = cInTgt[1:0] - 2'b01;

   // *****************************************
   // Code channel state
   // *****************************************
   always @* begin
      cState_nxt = cState_r;
      case (cState_r)
         ST_IDLE: begin
            if (cGrant) begin
               cState_nxt = cRefuse ? ST_FAIL : ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (cAck) begin
               cState_nxt = ST_IDLE;
            end
         end
         ST_FAIL: begin
            cState_nxt = ST_IDLE;
         end
         default: begin
            cState_nxt = ST_IDLE;
         end
      endcase
   end

   // Target strobes are held from grant until the acknowledge.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cState_r <= ST_IDLE;
         cOwnF_r <= 1'b0;
         cByte_r <= 1'b0;
         cSel_r <= 4'h0;
         cAddr_r <= 24'h000000;
         cWe_r <= 1'b0;
         cBe_r <= 2'h0;
         cWdata_r <= 16'h0000;
      end else begin
         cState_r <= cState_nxt;
         if (cGrant) begin
            cOwnF_r <= cGrantF;
            cByte_r <= cInByte;
            cAddr_r <= cInAddr;
            cWe_r <= cInWe;
            cBe_r <= cInByte ? (cInAddr[0] ? 2'b10 : 2'b01) : 2'b11;
            cWdata_r <= cInByte ? {dWdata[7:0], dWdata[7:0]} : dWdata;
            if (!cRefuse) begin
               cSel_r <= 4'h1 << cLane;
            end
         end else if (cState_r == ST_BUSY && cAck) begin
            cSel_r <= 4'h0;
         end
      end
   end

   // *****************************************
   // Data channel state
   // *****************************************
   always @* begin
      xState_nxt = xState_r;
      case (xState_r)
         ST_IDLE: begin
            if (xGrant) begin
               xState_nxt = xToBus ? ST_BUSY : ST_NULL;
            end
         end
         ST_BUSY: begin
            if (xAck) begin
               xState_nxt = ST_IDLE;
            end
         end
         ST_NULL: begin
            xState_nxt = ST_IDLE;
         end
         default: begin
            xState_nxt = ST_IDLE;
         end
      endcase
   end

   // Without an external bus a stray access drives no lane, so no
   // on-chip memory is hit.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         xState_r <= ST_IDLE;
         xOwnF_r <= 1'b0;
         xByte_r <= 1'b0;
         xSel_r <= 8'h00;
         xAddr_r <= 24'h000000;
         xWe_r <= 1'b0;
         xBe_r <= 2'h0;
         xWdata_r <= 16'h0000;
      end else begin
         xState_r <= xState_nxt;
         if (xGrant) begin
            xOwnF_r <= xGrantF;
            xByte_r <= xInByte;
            xAddr_r <= xInAddr;
            xWe_r <= xInWe;
            xBe_r <= xInByte ? (xInAddr[0] ? 2'b10 : 2'b01) : 2'b11;
            xWdata_r <= xInByte ? {dWdata[7:0], dWdata[7:0]} : dWdata;
            if (xInTgt != `TGT_EXT || hasExtBus) begin
               xSel_r <= 8'h01 << xLane;
            end
         end else if (xState_r == ST_BUSY && xAck) begin
            xSel_r <= 8'h00;
         end
      end
   end

   // *****************************************
   // Read data shaping
   // *****************************************
   // The flash hands over a whole 128-bit line; the word is picked here.
   assign cWord = cLine[{cAddr_r[3:1], 4'h0} +: 16];
   // Byte reads always land in the low lane with the high byte zero.
   assign cResult = !cByte_r ? cWord
                  : {8'h00, cAddr_r[0] ? cWord[15:8] : cWord[7:0]};
   assign xResult = !xByte_r ? xRdata
                  : {8'h00, xAddr_r[0] ? xRdata[15:8] : xRdata[7:0]};
   assign cDone = (cState_r == ST_BUSY && cAck) || cState_r == ST_FAIL;
   assign xDone = (xState_r == ST_BUSY && xAck) || xState_r == ST_NULL;

   // *****************************************
   // Bit addressing
   // *****************************************
   // The active register bank may sit anywhere inside the dual-port RAM.
   assign bankOfs = dAddr[15:0] - contextPtr;
   assign bitOk = dTgt == `TGT_SPEC || dTgt == `TGT_EXTD
      || (dTgt == `TGT_DUAL && dAddr >= `DUAL_BIT_LO)
      || (dTgt == `TGT_DUAL && dAddr[15:0] >= contextPtr
          && bankOfs < `BANK_BYTES);

   // *****************************************
   // Answers to the masters
   // *****************************************
   // One transfer per master in flight, so two channels never
   // complete for one master in one cycle.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fBusy_r <= 1'b0;
         fValid_r <= 1'b0;
         fData_r <= 16'h0000;
         fErr_r <= 1'b0;
      end else begin
         fValid_r <= 1'b0;
         if (fRdy) begin
            fBusy_r <= 1'b1;
         end
         if (cDone && cOwnF_r) begin
            fBusy_r <= 1'b0;
            fValid_r <= 1'b1;
            fData_r <= cState_r == ST_FAIL ? 16'h0000 : cResult;
            fErr_r <= cState_r == ST_FAIL || cEccErr;
         end else if (xDone && xOwnF_r) begin
            fBusy_r <= 1'b0;
            fValid_r <= 1'b1;
            fData_r <= xState_r == ST_NULL ? 16'h0000 : xResult;
            fErr_r <= 1'b0;
         end
      end
   end

   // Data results; a null completion reads zero and reports no error.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dBusy_r <= 1'b0;
         dValid_r <= 1'b0;
         dRdata_r <= 16'h0000;
         dErr_r <= 1'b0;
         dBitOk_r <= 1'b0;
      end else begin
         dValid_r <= 1'b0;
         if (dRdy) begin
            dBusy_r <= 1'b1;
            dBitOk_r <= bitOk;
         end
         if (cDone && !cOwnF_r) begin
            dBusy_r <= 1'b0;
            dValid_r <= 1'b1;
            dRdata_r <= cState_r == ST_FAIL ? 16'h0000 : cResult;
            dErr_r <= cState_r == ST_FAIL || cEccErr;
         end else if (xDone && !xOwnF_r) begin
            dBusy_r <= 1'b0;
            dValid_r <= 1'b1;
            dRdata_r <= xState_r == ST_NULL ? 16'h0000 : xResult;
            dErr_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== msd_properties.sv ====
// Checker of lane selection and result timing of the memory space decoder.
`timescale 1ns/10ps
`default_nettype none
module msd_properties (
   input wire clk,
   input wire rst_n,
   input wire hasExtBus,
   input wire fReq,
   input wire [23:0] fAddr,
   input wire fRdy,
   input wire fValid_r,
   input wire fErr_r,
   input wire dReq,
   input wire dWe,
   input wire [23:0] dAddr,
   input wire dRdy,
   input wire dValid_r,
   input wire dErr_r,
   input wire [15:0] dRdata_r,
   input wire dBitOk_r,
   input wire [3:0] cSel_r,
   input wire [7:0] xSel_r,
   input wire xAck
);
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Accepts and the external window.
   wire fTk = fReq && fRdy;
   wire dTk = dReq && dRdy;
   wire dExt = dAddr[23:22] != 2'b00 && dAddr[23:22] != 2'b11;
   // Refused or null: no lane, answer one edge later.
   sequence s_fnull;
      cSel_r == 4'h0 ##1 fValid_r && fErr_r;
   endsequence
   sequence s_dnull;
      xSel_r == 8'h00 ##1 dValid_r && !dErr_r && dRdata_r == 16'h0000;
   endsequence
   property p_xhot; $onehot0(xSel_r); endproperty
   property p_chot; $onehot0(cSel_r); endproperty
   property p_dram; dTk && dAddr >= 24'h00A000 && dAddr <= 24'h00DFFF |=> xSel_r == 8'h01; endproperty
   property p_sfr; dTk && dAddr[23:9] == 15'h007F |=> xSel_r == 8'h08; endproperty
   property p_fl1; fTk && fAddr[23:16] == 8'hC4 |=> cSel_r == 4'h2; endproperty
   property p_pram; fTk && fAddr[23:14] == 10'h380 |=> cSel_r == 4'h4; endproperty
   property p_rsv; fTk && fAddr[23:12] == 12'hC0F |=> s_fnull; endproperty
   property p_ext; dTk && dExt && hasExtBus |=> xSel_r == 8'h80; endproperty
   property p_noext; dTk && dExt && !hasExtBus && !dWe |=> s_dnull; endproperty
   property p_bit; dTk && dAddr[23:8] == 16'h00FD |=> dBitOk_r; endproperty
   // A lane holds until its target answers.
   property p_hold; xSel_r != 8'h00 && !xAck |=> $stable(xSel_r); endproperty
   a_xhot: assert property (p_xhot) else $error("data lanes not one-hot");
   a_chot: assert property (p_chot) else $error("code lanes not one-hot");
   a_dram: assert property (p_dram) else $error("data RAM lane missed");
   a_sfr: assert property (p_sfr) else $error("register lane missed");
   a_fl1: assert property (p_fl1) else $error("flash1 lane missed");
   a_pram: assert property (p_pram) else $error("program RAM lane missed");
   a_rsv: assert property (p_rsv) else $error("reserved sector not refused");
   a_ext: assert property (p_ext) else $error("external access not forwarded");
   a_noext: assert property (p_noext) else $error("external access not null");
   a_bit: assert property (p_bit) else $error("upper dual-port RAM not bit-able");
   a_hold: assert property (p_hold) else $error("data lane moved early");
endmodule
bind memory_space_decoder msd_properties u_msd_properties (.*);
`default_nettype wire

// ==== lane_targets.sv ====
// Memory targets answering the code and data lanes of the decoder.
`timescale 1ns/10ps
`default_nettype none
module lane_targets (
   input wire clk,
   input wire [1:0] lat,
   input wire ecc,
   input wire [3:0] cSel_r,
   input wire [23:0] cAddr_r,
   output logic cAck,
   output logic [127:0] cLine,
   output logic cEccErr,
   input wire [7:0] xSel_r,
   input wire [23:0] xAddr_r,
   input wire xWe_r,
   input wire [1:0] xBe_r,
   input wire [15:0] xWdata_r,
   output logic xAck,
   output logic [15:0] xRdata
);
   // ********************
   // Targets
   // ********************
   logic [15:0] mem [0:255];
   logic [1:0] cWait = 2'h0;
   logic [1:0] xWait = 2'h0;
   integer i;
   initial {cAck, cLine, cEccErr, xAck, xRdata} = '0;
   // Lines toggle outside an answer, so stale values fail.
   always @(posedge clk) begin
      cAck <= 1'b0;
      cLine <= ~cLine;
      cEccErr <= ~cEccErr;
      cWait <= 2'h0;
      if (cSel_r != 4'h0 && !cAck) begin
         if (cWait == lat) begin
            cAck <= 1'b1;
            cEccErr <= ecc;
            for (i = 0; i < 8; i = i + 1)
               cLine[i*16 +: 16] <= {cAddr_r[15:4], 1'b0, i[2:0]};
         end else cWait <= cWait + 2'h1;
      end
   end
   // Byte-enabled word memory; lat sets the wait.
   always @(posedge clk) begin
      xAck <= 1'b0;
      xRdata <= ~xRdata;
      xWait <= 2'h0;
      if (xSel_r != 8'h00 && !xAck) begin
         if (xWait == lat) begin
            xAck <= 1'b1;
            xRdata <= mem[xAddr_r[8:1]];
            if (xWe_r && xBe_r[0]) mem[xAddr_r[8:1]][7:0] <= xWdata_r[7:0];
            if (xWe_r && xBe_r[1]) mem[xAddr_r[8:1]][15:8] <= xWdata_r[15:8];
         end else xWait <= xWait + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the memory space decoder.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ********************
   // Bench
   // ********************
   logic clk, rst_n, hasExtBus, rdProtEn, relock, fReq, dReq, dWe, dByte, ecc, er, fer;
   logic [15:0] contextPtr, pwdWord0, pwdWord1, dWdata, rd, frd;
   logic [19:0] wpCluster;
   logic [13:0] pramWpTop;
   logic [23:0] fAddr, dAddr;
   logic [1:0] lat;
   integer errors, total_checks, i;
   time fT, dT;
   wire fRdy, fValid_r, fErr_r, dRdy, dValid_r, dErr_r, dBitOk_r, flashUnlocked;
   wire cWe_r, cAck, cEccErr, xWe_r, xAck;
   wire [15:0] fData_r, dRdata_r, cWdata_r, xWdata_r, xRdata;
   wire [3:0] cSel_r;
   wire [23:0] cAddr_r, xAddr_r;
   wire [1:0] cBe_r, xBe_r;
   wire [127:0] cLine;
   wire [7:0] xSel_r;
   // Only mapped, used register places are touched.
   logic [23:0] tbl [0:6] = '{24'h00A004, 24'h00FE12, 24'h00F016, 24'h00F708,
      24'h00E00A, 24'h20C00C, 24'h20000E};
   memory_space_decoder u_memory_space_decoder (.*);
   lane_targets u_lane_targets (.*);
   always #10 clk = ~clk;
   task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until accepted, then wait for the result.
   task automatic acc(input logic f, w, b, input logic [23:0] a, input logic [15:0] wd,
      output logic [15:0] q, output logic e, output time t);
      integer n;
      if (f) begin
         fReq <= 1'b1;
         fAddr <= a;
      end else begin
         dReq <= 1'b1;
         dWe <= w;
         dByte <= b;
         dAddr <= a;
         dWdata <= wd;
      end
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while ((f ? fRdy : dRdy) !== 1'b1 && n < 50);
      t = $time;
      if (f) fReq <= 1'b0;
      else dReq <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while ((f ? fValid_r : dValid_r) !== 1'b1 && n < 50);
      q = f ? fData_r : dRdata_r;
      e = f ? fErr_r : dErr_r;
   endtask
   task automatic dw(input logic [23:0] a, input logic [15:0] v);
      acc(1'b0, 1'b1, 1'b0, a, v, rd, er, dT);
   endtask
   task automatic dr(input logic [23:0] a);
      acc(1'b0, 1'b0, 1'b0, a, 16'h0000, rd, er, dT);
   endtask
   task automatic fr(input logic [23:0] a);
      acc(1'b1, 1'b0, 1'b0, a, 16'h0000, frd, fer, fT);
   endtask
   // Every on-chip data target but the flash register page, answered slowly, then byte lanes.
   task automatic t_regs;
      lat <= 2'h2;
      for (i = 0; i < 7; i = i + 1) dw(tbl[i], tbl[i][15:0] ^ 16'h5A5A);
      for (i = 0; i < 7; i = i + 1) begin
         dr(tbl[i]);
         check("rdata", rd, tbl[i][15:0] ^ 16'h5A5A);
      end
      acc(1'b0, 1'b1, 1'b1, 24'h00A005, 16'h009E, rd, er, dT);
      dr(24'h00A004);
      check("word", rd, 16'h9E5E);
      acc(1'b0, 1'b0, 1'b1, 24'h00A005, 16'h0000, rd, er, dT);
      check("byte", rd, 16'h009E);
      lat <= 2'h0;
   endtask
   task automatic t_bits;
      logic [23:0] ba [0:4];
      ba = '{24'h00FD00, 24'h00F600, 24'h00F81E, 24'h00F820, 24'h00FE00};
      contextPtr <= 16'hF800;
      for (i = 0; i < 5; i = i + 1) begin
         dr(ba[i]);
         check("bitok", dBitOk_r, (5'b10101 >> i) & 1);
      end
   endtask
   task automatic t_fetch;
      logic [23:0] fa [0:3];
      fa = '{24'hC00010, 24'hC40022, 24'hE00006, 24'hE80004};
      for (i = 0; i < 4; i = i + 1) begin
         fr(fa[i]);
         check("fdata", frd, {fa[i][15:4], 1'b0, fa[i][3:1]});
         check("ferr", fer, 1'b0);
      end
      ecc <= 1'b1;
      fr(24'hC00030);
      check("eccerr", fer, 1'b1);
      ecc <= 1'b0;
      fr(24'hC0F000);
      check("rsverr", fer, 1'b1);
      check("rsvdata", frd, 16'h0000);
   endtask
   task automatic t_flash;
      rdProtEn <= 1'b1;
      wpCluster <= 20'h00001;
      dr(24'hC00020);
      check("rdlock", er, 1'b1);
      fr(24'hC00020);
      check("fetchok", fer, 1'b0);
      dw(24'hC00000, 16'h0001);
      check("wplock", er, 1'b1);
      dw(24'hC04000, 16'h0001);
      check("wpfree", er, 1'b0);
      dw(24'hFFFF02, pwdWord1);
      check("unlk0", flashUnlocked, 1'b0);
      dw(24'hFFFF00, pwdWord0);
      dw(24'hFFFF02, pwdWord1);
      check("unlk1", flashUnlocked, 1'b1);
      dr(24'hC00020);
      check("rdopen", rd, 16'h0020);
      relock <= 1'b1;
      @(posedge clk);
      relock <= 1'b0;
      @(posedge clk);
      check("relock", flashUnlocked, 1'b0);
      rdProtEn <= 1'b0;
      wpCluster <= 20'h00000;
   endtask
   task automatic t_pram;
      pramWpTop <= 14'h0100;
      dw(24'hE00010, 16'h0002);
      check("pwp", er, 1'b1);
      dw(24'hE00200, 16'h0002);
      check("pfree", er, 1'b0);
      pramWpTop <= 14'h0000;
   endtask
   // The external write aliases a data RAM word in the target model.
   task automatic t_ext;
      dw(24'h400004, 16'h1234);
      dr(24'h400004);
      check("nobus", rd, 16'h0000);
      check("nobuserr", er, 1'b0);
      dr(24'h00A004);
      check("intact", rd, 16'h9E5E);
      hasExtBus <= 1'b1;
      dw(24'h400004, 16'h1234);
      dr(24'h400004);
      check("extbus", rd, 16'h1234);
      hasExtBus <= 1'b0;
   endtask
   task automatic t_both;
      fork
         fr(24'hE00006);
         dr(24'h00A004);
      join
      check("sametime", dT == fT, 1'b1);
      check("bothd", rd, 16'h1234);
      check("bothf", frd, 16'h0003);
   endtask
   task automatic print_verdict;
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      {clk, rst_n, hasExtBus, rdProtEn, relock, fReq, dReq, dWe, dByte, ecc} = '0;
      {contextPtr, dWdata, wpCluster, pramWpTop, fAddr, dAddr, lat} = '0;
      pwdWord0 = 16'h5A3C;
      pwdWord1 = 16'hC3A5;
      errors = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_bits;
      t_fetch;
      t_flash;
      t_pram;
      t_ext;
      t_both;
      print_verdict;
   end
   // Tests need under 1000 cycles.
   initial begin
      repeat (5000) @(posedge clk);
      errors = errors + 1;
      print_verdict;
   end
endmodule
`default_nettype wire
